// ===== core/adc_cfg_bank.sv
// serial-port configuration bank: port config, identity, grade, shadow commit
//
// How it works
// - unmapped addresses and bits do nothing
// - port config mirrored nibbles, resets to 0x18
// - address 0x01 returns fixed identity, read only
// - transfer bit copies shadows to live one cycle after its byte
// - 0x08..0x18 stay shadowed until transfer, autoclear
// - shift msb first after reset
`timescale 1ns/1ps
`include "adc_cfg_regs.svh"

module adc_cfg_bank
	import adc_cfg_pkg::*;
#(
	parameter logic [7:0] IDENTITY_P    = 8'h5a, // arbitrary value
	parameter logic [7:0] SPEED_GRADE_P = 8'h00
)
(
	// clock, reset, enable
	input  wire logic    i_mclk,
	input  wire logic    i_rst_n,
	input  wire logic    i_ce,
	// serial port pins
	input  wire logic    i_csb_n,
	input  wire logic    i_sclk,
	input  wire logic    i_sdio,
	output logic         o_sdio,
	output logic         o_sdio_oe_n,
	// committed configuration
	output shadow_t      o_live,
	output logic         o_lsb_first
);

	// ----------------------------------------------------------------
	// elaboration check
	// ----------------------------------------------------------------
	if (SPEED_GRADE_P > 8'h07)
	begin : g_bad_grade
		$error("speed grade code must fit in three bits");
	end

	state_t s_q;
	state_t s_d;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic sync_t sync_step(input sync_t s, input logic pin);
		sync_t r;
		r = s;
		r.chain = {s.chain[1:0], pin};
		// the first stage feeds only the second
		if (s.chain[1] == s.chain[2])
		begin
			r.level = s.chain[2];
		end
		return r;
	endfunction

	function automatic logic in_shadow(input logic [12:0] a);
		return (a >= `ADDR_SHADOW_FIRST) && (a <= `ADDR_SHADOW_LAST);
	endfunction

	function automatic logic [7:0] reg_read(input state_t s, input logic [12:0] a);
		logic [7:0] v;
		v = 8'h00;
		if (a == `ADDR_PORT_CFG)
		begin
			v = `PORT_CFG_RESET;
			v[`PORT_LSB_HI] = s.lsb_first;
			v[`PORT_LSB_LO] = s.lsb_first;
			v[`PORT_SRST_HI] = s.soft_rst;
			v[`PORT_SRST_LO] = s.soft_rst;
		end
		else if (a == `ADDR_IDENTITY)
		begin
			v = IDENTITY_P;
		end
		else if (a == `ADDR_SPEED_GRADE)
		begin
			v = 8'((SPEED_GRADE_P & 8'h07) << `GRADE_LSB);
		end
		else if (a == `ADDR_COMMIT)
		begin
			v = 8'({7'h00, s.commit});
		end
		else if (in_shadow(a))
		begin
			v = s.shadow[5'(a - `ADDR_SHADOW_FIRST)];
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	logic       rise;
	logic       fall;
	logic [7:0] wbyte;

	always_comb
	begin
		s_d = s_q;
		rise = 1'b0;
		fall = 1'b0;
		wbyte = 8'h00;
		s_d.csb = sync_step(s_q.csb, i_csb_n);
		s_d.sclk = sync_step(s_q.sclk, i_sclk);
		s_d.sdio = sync_step(s_q.sdio, i_sdio);
		rise = s_d.sclk.level && !s_q.sclk.level;
		fall = !s_d.sclk.level && s_q.sclk.level;

		// commit and soft reset act one cycle after the byte that asks for them
		if (s_q.commit)
		begin
			s_d.live = s_q.shadow;
			s_d.commit = 1'b0;
		end
		if (s_q.soft_rst)
		begin
			s_d.soft_rst = 1'b0;
			s_d.lsb_first = 1'b0;
			s_d.shadow = '0;
			s_d.live = '0;
			s_d.commit = 1'b0;
		end

		if (s_q.csb.level)
		begin
			// frame ends on the chip-select; stop driving at once
			s_d.phase = PH_IDLE;
			s_d.sdio_oe_n = 1'b1;
			s_d.sdio_out = 1'b0;
		end
		else
		begin
			if (s_q.phase == PH_IDLE)
			begin
				s_d.phase = PH_INSTR;
				s_d.cnt = 5'h00;
				s_d.frame_lsb = s_q.lsb_first;
			end
			unique case (s_q.phase)
				PH_IDLE:
				begin
				end
				PH_INSTR:
				begin
					if (rise)
					begin
						s_d.sh = s_q.frame_lsb ? {s_d.sdio.level, s_q.sh[15:1]}
							: {s_q.sh[14:0], s_d.sdio.level};
						s_d.cnt = 5'(s_q.cnt + 5'h01);
						if (s_d.cnt == `INSTR_BITS)
						begin
							s_d.phase = PH_DATA;
							s_d.cnt = 5'h00;
							s_d.rd = s_d.sh[15];
							s_d.stream = s_d.sh[14:13] == `LEN_STREAM;
							s_d.left = s_d.sh[14:13];
							s_d.addr = s_d.sh[12:0];
							s_d.tx = reg_read(s_q, s_d.sh[12:0]);
						end
					end
				end
				PH_DATA:
				begin
					if (fall && s_q.rd)
					begin
						s_d.sdio_oe_n = 1'b0;
						s_d.sdio_out = s_q.frame_lsb ? s_q.tx[s_q.cnt[2:0]]
							: s_q.tx[~s_q.cnt[2:0]];
					end
					if (rise)
					begin
						s_d.sh = s_q.frame_lsb ? {s_d.sdio.level, s_q.sh[15:1]}
							: {s_q.sh[14:0], s_d.sdio.level};
						s_d.cnt = 5'(s_q.cnt + 5'h01);
						if (s_d.cnt == 5'h08)
						begin
							s_d.cnt = 5'h00;
							wbyte = s_q.frame_lsb ? s_d.sh[15:8] : s_d.sh[7:0];
							if (!s_q.rd)
							begin
								// read-only and unmapped locations take no write
								if (s_q.addr == `ADDR_PORT_CFG)
								begin
									s_d.lsb_first = wbyte[`PORT_LSB_HI] | wbyte[`PORT_LSB_LO];
									s_d.soft_rst = wbyte[`PORT_SRST_HI] | wbyte[`PORT_SRST_LO];
								end
								else if (s_q.addr == `ADDR_COMMIT)
								begin
									// a new request wins over the autoclear
									s_d.commit = wbyte[`COMMIT_BIT];
								end
								else if (in_shadow(s_q.addr))
								begin
									s_d.shadow[5'(s_q.addr - `ADDR_SHADOW_FIRST)] = wbyte;
								end
							end
							// msb-first frames walk down, lsb-first frames walk up
							s_d.addr = s_q.frame_lsb ? 13'(s_q.addr + 13'h0001)
								: 13'(s_q.addr - 13'h0001);
							s_d.tx = reg_read(s_d, s_d.addr);
							if (!s_q.stream)
							begin
								s_d.left = 2'(s_q.left - 2'h1);
								if (s_q.left == 2'h0)
								begin
									s_d.phase = PH_DONE;
								end
							end
						end
					end
				end
				PH_DONE:
				begin
					// extra clocks after the last byte are ignored
					if (fall)
					begin
						s_d.sdio_oe_n = 1'b1;
						s_d.sdio_out = 1'b0;
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			s_q <= '0;
			s_q.csb <= '{chain: 3'h7, level: 1'b1};
			s_q.sdio_oe_n <= 1'b1;
		end
		else if (i_ce)
		begin
			s_q <= s_d;
		end
	end

	assign o_sdio = s_q.sdio_out;
	assign o_sdio_oe_n = s_q.sdio_oe_n;
	assign o_live = s_q.live;
	assign o_lsb_first = s_q.lsb_first;

endmodule // adc_cfg_bank

// ===== include/adc_cfg_pkg.sv
// types shared by the serial configuration register bank
`include "adc_cfg_regs.svh"
package adc_cfg_pkg;

	typedef logic [`SHADOW_COUNT-1:0][7:0] shadow_t;

	typedef enum logic [1:0]
	{
		PH_IDLE,
		PH_INSTR,
		PH_DATA,
		PH_DONE
	} phase_t;

	// three-stage synchroniser with its filtered level
	typedef struct packed {
		logic [2:0] chain;
		logic       level;
	} sync_t;

	typedef struct packed {
		sync_t       csb;
		sync_t       sclk;
		sync_t       sdio;
		phase_t      phase;
		logic [15:0] sh;
		logic [4:0]  cnt;
		logic        rd;
		logic [1:0]  left;
		logic        stream;
		logic [12:0] addr;
		logic        frame_lsb;
		logic [7:0]  tx;
		logic        sdio_out;
		logic        sdio_oe_n;
		logic        lsb_first;
		logic        soft_rst;
		logic        commit;
		shadow_t     shadow;
		shadow_t     live;
	} state_t;

endpackage

// ===== include/adc_cfg_regs.svh
// register offsets, field positions, reset values and sizes of the config bank
`ifndef ADC_CFG_REGS_SVH
`define ADC_CFG_REGS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define ADDR_PORT_CFG      13'h0000
`define ADDR_IDENTITY      13'h0001
`define ADDR_SPEED_GRADE   13'h0002
`define ADDR_COMMIT        13'h00ff
`define ADDR_SHADOW_FIRST  13'h0008
`define ADDR_SHADOW_LAST   13'h0018
`define SHADOW_COUNT       17

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PORT_CFG_RESET     8'h18
`define PORT_LSB_HI        6
`define PORT_LSB_LO        1
`define PORT_SRST_HI       5
`define PORT_SRST_LO       2
`define GRADE_LSB          4
`define COMMIT_BIT         0
`define COMMIT_RESET       8'h00
`define SHADOW_RESET       8'h00

// ----------------------------------------------------------------
// serial framing
// ----------------------------------------------------------------
`define INSTR_BITS         5'h10
`define LEN_STREAM         2'h3

`endif

// ===== verification/adc_cfg_bank_chk.sv
// pin-level assertions for the config bank
`timescale 1ns/1ps
module adc_cfg_bank_chk
	import adc_cfg_pkg::*;
(
	// clock and reset
	input wire logic    i_mclk,
	input wire logic    i_rst_n,
	// pins
	input wire logic    i_ce,
	input wire logic    i_csb_n,
	input wire logic    i_sclk,
	input wire logic    i_sdio,
	input wire logic    o_sdio,
	input wire logic    o_sdio_oe_n,
	input wire shadow_t o_live,
	input wire logic    o_lsb_first
);
	// ----------
	// assertions
	// ----------
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rst_n);
	rst_vals_a: assert property (disable iff (1'b0) !i_rst_n |=> o_live == '0
		&& !o_lsb_first && o_sdio_oe_n) else $error("reset values wrong");
	ce_hold_a: assert property (!i_ce |=> $stable(o_live)) else $error("frozen moved");
	live_frame_a: assert property ($changed(o_live) |-> !$past(i_csb_n, 3))
		else $error("live changed idle");
	live_idle_a: assert property (i_csb_n[*8] |=> $stable(o_live)) else $error("live moved");
	lsb_idle_a: assert property (i_csb_n[*8] |=> $stable(o_lsb_first))
		else $error("order moved");
	oe_idle_a: assert property (i_csb_n[*8] |-> o_sdio_oe_n) else $error("drives idle");
	oe_frame_a: assert property ($fell(o_sdio_oe_n) |-> !$past(i_csb_n, 8))
		else $error("drives early");
	sdio_hold_a: assert property ((i_sclk && !i_csb_n)[*8] |-> $stable(o_sdio))
		else $error("data moved");
endmodule // adc_cfg_bank_chk

// ===== verification/adc_cfg_master.sv
// serial master model for the config bank pins
`timescale 1ns/1ps
module adc_cfg_master
(
	input  wire logic i_mclk,
	input  wire logic i_sdio,
	output logic      o_csb_n,
	output logic      o_sclk,
	output logic      o_sdio
);
	// ------------
	// frame driver
	// ------------
	initial
	begin
		o_csb_n = 1'b1;
		o_sclk = 1'b0;
		o_sdio = 1'b0;
	end
	task automatic half();
		repeat (10) @(negedge i_mclk);
	endtask
	// clock rests low between frames; nb data bytes, the first one in bits 7:0
	task automatic frame(input logic lsb, input logic [15:0] ins, input int nb,
		input logic [23:0] wd, output logic [23:0] rd);
		int b;
		rd = 24'h000000;
		o_csb_n = 1'b0;
		half();
		for (int i = 0; i < 16 + 8 * nb; i++)
		begin
			b = lsb ? i % 8 : 7 - i % 8;
			if (i < 16)
				o_sdio = lsb ? ins[i] : ins[15 - i];
			else if (ins[15])
				o_sdio = ~o_sdio; // released line never keeps its last value
			else
				o_sdio = wd[8 * (i / 8 - 2) + b];
			half();
			o_sclk = 1'b1;
			if (i > 15)
				rd[8 * (i / 8 - 2) + b] = i_sdio;
			half();
			o_sclk = 1'b0;
		end
		half();
		o_csb_n = 1'b1;
		half();
	endtask
endmodule // adc_cfg_master

// ===== verification/tb_adc_cfg_bank.sv
// self-checking bench for the config bank
`timescale 1ns/1ps
module tb_adc_cfg_bank;
	import adc_cfg_pkg::*;
	logic       i_mclk = 1'b0;
	logic       i_rst_n = 1'b0;
	logic       i_ce = 1'b1;
	logic       lsb = 1'b0;
	logic       csb_n, sclk, m_sdio, o_sdio, o_sdio_oe_n, o_lsb_first;
	logic [23:0] rd;
	logic [7:0]  v;
	shadow_t    o_live, exp_live;
	int         n_mismatch = 0;
	int         n_checks = 0;
	int         seed = 32'h2c6cd7cb;
	wire        sdio = o_sdio_oe_n ? m_sdio : o_sdio;
	always #4 i_mclk = ~i_mclk;
	// identity value is arbitrary
	adc_cfg_bank #(.IDENTITY_P(8'h3c), .SPEED_GRADE_P(8'h05)) adc_cfg_bank_inst (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_csb_n(csb_n), .i_sclk(sclk),
		.i_sdio(sdio), .o_sdio(o_sdio), .o_sdio_oe_n(o_sdio_oe_n), .o_live(o_live),
		.o_lsb_first(o_lsb_first));
	adc_cfg_master adc_cfg_master_inst (.i_mclk(i_mclk), .i_sdio(sdio), .o_csb_n(csb_n),
		.o_sclk(sclk), .o_sdio(m_sdio));
	// -----
	// tasks
	// -----
	task automatic chk_b(input string s, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic chk_v(input shadow_t e);
		n_checks++;
		if (o_live !== e)
		begin
			n_mismatch++;
			$display("[FAIL] live expected %h seen %h", e, o_live);
		end
	endtask
	function automatic logic [7:0] exp_rd(input logic [12:0] a);
		case (a)
			13'h0000: return 8'h18 | {1'b0, lsb, 4'h0, lsb, 1'b0};
			13'h0001: return 8'h3c;
			13'h0002: return 8'h50;
			default: return 8'h00;
		endcase
	endfunction
	// msb-first frames walk the address down, lsb-first frames walk it up
	task automatic acc_n(input logic r, input logic [1:0] len, input logic [12:0] a,
		input int nb, input logic [23:0] d);
		adc_cfg_master_inst.frame(lsb, {r, len, a}, nb, d, rd);
		for (int k = 0; k < nb; k++)
		begin
			if (r)
				chk_b("read", exp_rd(lsb ? 13'(a + k) : 13'(a - k)), rd[8 * k +: 8]);
		end
	endtask
	task automatic acc(input logic r, input logic [12:0] a, input logic [7:0] d);
		acc_n(r, 2'h0, a, 1, {16'h0000, d});
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial
	begin
		#400000;
		n_mismatch++;
		wrap_up();
	end
	initial
	begin
		exp_live = '0;
		repeat (3) @(negedge i_mclk);
		i_rst_n = 1'b1;
		repeat (4) @(negedge i_mclk);
		chk_v(exp_live);
		chk_b("order", 8'h00, {7'h0, o_lsb_first});
		acc(0, 13'h0001, 8'hff);
		acc(1, 13'h0000, 8'h00);
		acc(1, 13'h0001, 8'h00);
		acc(1, 13'h0002, 8'h00);
		acc(1, 13'h0003, 8'h00);
		acc(1, 13'h00ff, 8'h00);
		acc_n(1, 2'h2, 13'h0002, 3, 24'h000000);
		$display("fixed bytes done");
		for (int i = 0; i < 17; i++)
		begin
			if (i == 11)
				continue; // omitted address is never written
			v = 8'($random(seed));
			exp_live[i] = v;
			acc(0, 13'(8 + i), v);
			i_ce = 1'b0;
			@(negedge i_mclk);
			i_ce = 1'b1;
		end
		v = 8'($random(seed));
		exp_live[1] = v;
		exp_live[0] = ~v;
		acc_n(0, 2'h1, 13'h0009, 2, {8'h00, ~v, v});
		chk_v('0);
		// enable chatters across the commit so a frozen cycle meets it
		fork
			acc(0, 13'h00ff, 8'h01);
			repeat (510)
			begin
				@(negedge i_mclk);
				i_ce = ~i_ce;
			end
		join
		chk_v(exp_live);
		acc(1, 13'h00ff, 8'h00);
		$display("commit done");
		acc(0, 13'h0000, 8'h42);
		lsb = 1'b1;
		chk_b("order", 8'h01, {7'h0, o_lsb_first});
		acc(1, 13'h0000, 8'h00);
		acc_n(1, 2'h3, 13'h0000, 2, 24'h000000);
		acc(0, 13'h0000, 8'h24);
		lsb = 1'b0;
		chk_b("order", 8'h00, {7'h0, o_lsb_first});
		chk_v('0);
		$display("port config done");
		v = 8'($random(seed));
		acc(0, 13'h0008, v);
		acc(0, 13'h00ff, 8'h01);
		exp_live = '0;
		exp_live[0] = v;
		chk_v(exp_live);
		acc(0, 13'h0000, 8'h42);
		// hard reset in mid-run must clear what the soft one cleared
		i_rst_n = 1'b0;
		repeat (3) @(negedge i_mclk);
		i_rst_n = 1'b1;
		repeat (4) @(negedge i_mclk);
		chk_v('0);
		chk_b("order", 8'h00, {7'h0, o_lsb_first});
		acc(1, 13'h0000, 8'h00);
		$display("reset done");
		wrap_up();
	end
endmodule // tb_adc_cfg_bank
bind adc_cfg_bank adc_cfg_bank_chk adc_cfg_bank_chk_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
	.i_ce(i_ce), .i_csb_n(i_csb_n), .i_sclk(i_sclk), .i_sdio(i_sdio), .o_sdio(o_sdio),
	.o_sdio_oe_n(o_sdio_oe_n), .o_live(o_live), .o_lsb_first(o_lsb_first));
